/* File: design/external_data_space_off_chip_memory_port.sv */
// external_data_space_off_chip_memory_port: effective address, target steering, on-chip ram, fifo window
// crossing and off-chip port claim for the external-data move
// assumes an apb master, a cpu move request port and a usb-clock fifo ram
`timescale 1ns/10ps

// How it works
// RULE1: register-operand move address is page byte over chosen index byte
// RULE2: pointer-form move uses the full 16-bit data pointer as address
// RULE3: data pointer readable and writable as high and low byte registers
// RULE4: on-chip ram, 4k or 2k, mapped into external-data space
// RULE5: moves target external-data space unless flash writing is enabled; the code redirects only writes, reads stay in external-data space
// RULE6: buffer enable routes 0x0400..0x07ff to the usb endpoint buffer
// RULE7: with buffer enabled, normal memory in that range is unreachable
// RULE8: endpoint buffer lives in usb clock domain; access crosses there
// RULE9: buffer moves take more system cycles than on-chip ram moves
// RULE10: software keeps move accesses away from live usb packet data
// RULE11: off-chip accesses use ports 4, 3, 2 and 1
// RULE12: pins claimed only during an off-chip move, then released
// RULE13: pins used as inputs have drivers off during the access
// RULE14: pin open-drain or push-pull mode is never touched here
// RULE15: software makes crossbar skip the strobe and latch pins
// RULE16: software parks interface pins high through the port latches
// RULE17: software configures pins, latches, mux, mode, then timing
// RULE18: software normally sets interface pins push-pull
// RULE19: buffer access enable is bit 6 of memory configuration
// RULE20: page register is 8 bits, selecting a 256-byte page
// RULE21: with flash write enable set, move writes go to program flash
// RULE22: buffer access stalls until usb-domain handshake confirms it
// RULE23: target decided before pins claimed; pins only for off-chip
module external_data_space_off_chip_memory_port #(
  parameter bit BIG_RAM = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // cpu move request
  input wire logic mv_req_i,
  input wire logic mv_wr_i,
  input wire logic mv_ptr_i,
  input wire logic mv_idx_i,
  input wire logic [7:0] mv_wdata_i,
  output logic mv_done_o,
  output logic [7:0] mv_rdata_o,
  // flash write path
  output logic fl_wr_o,
  output logic [15:0] fl_addr_o,
  output logic [7:0] fl_data_o,
  // usb-domain buffer handshake, toggle style
  output logic fifo_req_tgl_o,
  output logic fifo_wr_o,
  output logic [9:0] fifo_addr_o,
  output logic [7:0] fifo_wdata_o,
  input wire logic fifo_ack_tgl_i,
  input wire logic [7:0] fifo_rdata_i,
  // port pins: address high, address low, data, strobes
  output logic off_chip_memory_port_claim_o,
  output logic [7:0] ahi_o,
  output logic ahi_oe_o,
  output logic [7:0] alo_o,
  output logic alo_oe_o,
  output logic [7:0] dat_o,
  output logic dat_oe_o,
  input wire logic [7:0] dat_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ale_o
);
  import external_data_space_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0] page_q, cfg_q, dph_q, dpl_q, r0_q, r1_q, flctl_q;
  logic [7:0] ram_q [0:4095];
  external_data_space_state_t st_q;
  external_data_space_tgt_t tgt_q;
  logic [15:0] ea_q;
  logic wr_q;
  logic [7:0] wd_q;
  logic [3:0] cnt_q;
  logic ack_s1_q, ack_s2_q, ack_seen_q;
  logic [7:0] d_s1_q, d_s2_q;
  // off-chip read data comes from pins, so it is synchronised too
  logic [7:0] dat_s1_q, dat_s2_q;
  logic ptr_q;
  logic [15:0] mask;
  logic [1:0] emd;

  assign mask = BIG_RAM ? EXTERNAL_DATA_SPACE_ONCHIP_MASK_4K : EXTERNAL_DATA_SPACE_ONCHIP_MASK_2K; // RULE4
  assign emd = cfg_q[EXTERNAL_DATA_SPACE_CFG_EMD_LSB +: 2];

  // effective address of a move
  function automatic logic [15:0] eff_addr(input logic ptr,
      input logic idx, input logic [7:0] pg, input logic [7:0] dh,
      input logic [7:0] dl, input logic [7:0] i0, input logic [7:0] i1);
    if (ptr) begin
      eff_addr = {dh, dl}; // RULE2
    end else begin
      eff_addr = {pg, idx ? i1 : i0}; // RULE1 RULE20
    end
  endfunction

  // target decode, made before any pin is claimed
  function automatic external_data_space_tgt_t decode(input logic [15:0] a,
      input logic wr, input logic fae, input logic fwe,
      input logic [1:0] md, input logic [15:0] m);
    if (wr && fwe) begin
      decode = EXTERNAL_DATA_SPACE_TGT_FLASH; // RULE5 RULE21
    end else if (fae && a >= EXTERNAL_DATA_SPACE_FIFO_LO && a <= EXTERNAL_DATA_SPACE_FIFO_HI) begin
      decode = EXTERNAL_DATA_SPACE_TGT_FIFO; // RULE6 RULE7
    end else begin
      case (md)
        EXTERNAL_DATA_SPACE_EMD_INT: decode = EXTERNAL_DATA_SPACE_TGT_ONCHIP;
        EXTERNAL_DATA_SPACE_EMD_EXT: decode = EXTERNAL_DATA_SPACE_TGT_OFFCHIP;
        default: decode = ((a & ~m) == 16'h0000) ? EXTERNAL_DATA_SPACE_TGT_ONCHIP :
          EXTERNAL_DATA_SPACE_TGT_OFFCHIP; // RULE23
      endcase
    end
  endfunction

  // ==========================================================================
  // apb slave: one wait-free access phase
  logic apb_acc, apb_wr;
  assign apb_acc = psel_i && penable_i;
  assign apb_wr = apb_acc && pwrite_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_q <= EXTERNAL_DATA_SPACE_PAGE_RST;
      cfg_q <= EXTERNAL_DATA_SPACE_CFG_RST;
      dph_q <= 8'h00;
      dpl_q <= 8'h00;
      r0_q <= 8'h00;
      r1_q <= 8'h00;
      flctl_q <= 8'h00;
    end else if (apb_wr) begin
      case (paddr_i)
        EXTERNAL_DATA_SPACE_PAGE_OFF: page_q <= pwdata_i[7:0];
        EXTERNAL_DATA_SPACE_CFG_OFF: cfg_q <= pwdata_i[7:0] & EXTERNAL_DATA_SPACE_CFG_WMASK; // RULE19
        EXTERNAL_DATA_SPACE_DPH_OFF: dph_q <= pwdata_i[7:0]; // RULE3
        EXTERNAL_DATA_SPACE_DPL_OFF: dpl_q <= pwdata_i[7:0]; // RULE3
        EXTERNAL_DATA_SPACE_R0_OFF: r0_q <= pwdata_i[7:0];
        EXTERNAL_DATA_SPACE_R1_OFF: r1_q <= pwdata_i[7:0];
        EXTERNAL_DATA_SPACE_FLCTL_OFF: flctl_q <= {7'h00, pwdata_i[0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        case (paddr_i)
          EXTERNAL_DATA_SPACE_PAGE_OFF: prdata_o <= {24'h0, page_q};
          EXTERNAL_DATA_SPACE_CFG_OFF: prdata_o <= {24'h0, cfg_q};
          EXTERNAL_DATA_SPACE_DPH_OFF: prdata_o <= {24'h0, dph_q};
          EXTERNAL_DATA_SPACE_DPL_OFF: prdata_o <= {24'h0, dpl_q};
          EXTERNAL_DATA_SPACE_R0_OFF: prdata_o <= {24'h0, r0_q};
          EXTERNAL_DATA_SPACE_R1_OFF: prdata_o <= {24'h0, r1_q};
          EXTERNAL_DATA_SPACE_FLCTL_OFF: prdata_o <= {24'h0, flctl_q};
          EXTERNAL_DATA_SPACE_STAT_OFF: prdata_o <= {27'h0, st_q};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // ack crossing from the usb domain; data passes the same two stages alongside the ack
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      d_s1_q <= 8'h00;
      d_s2_q <= 8'h00;
      dat_s1_q <= 8'h00;
      dat_s2_q <= 8'h00;
    end else begin
      ack_s1_q <= fifo_ack_tgl_i; // RULE8
      ack_s2_q <= ack_s1_q;
      d_s1_q <= fifo_rdata_i;
      d_s2_q <= d_s1_q;
      dat_s1_q <= dat_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ==========================================================================
  // move controller
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= EXTERNAL_DATA_SPACE_S_IDLE;
      tgt_q <= EXTERNAL_DATA_SPACE_TGT_ONCHIP;
      ea_q <= 16'h0000;
      wr_q <= 1'b0;
      wd_q <= 8'h00;
      cnt_q <= 4'h0;
      ack_seen_q <= 1'b0;
      ptr_q <= 1'b0;
      mv_done_o <= 1'b0;
      mv_rdata_o <= 8'h00;
      fifo_req_tgl_o <= 1'b0;
      fl_wr_o <= 1'b0;
    end else begin
      mv_done_o <= 1'b0;
      fl_wr_o <= 1'b0;
      case (st_q)
        EXTERNAL_DATA_SPACE_S_IDLE: if (mv_req_i) begin
          ea_q <= eff_addr(mv_ptr_i, mv_idx_i, page_q, dph_q, dpl_q,
            r0_q, r1_q);
          tgt_q <= decode(eff_addr(mv_ptr_i, mv_idx_i, page_q, dph_q,
            dpl_q, r0_q, r1_q), mv_wr_i, cfg_q[EXTERNAL_DATA_SPACE_CFG_FAE_BIT],
            flctl_q[0], emd, mask); // RULE23
          wr_q <= mv_wr_i;
          ptr_q <= mv_ptr_i;
          wd_q <= mv_wdata_i;
          st_q <= EXTERNAL_DATA_SPACE_S_RAM;
        end
        EXTERNAL_DATA_SPACE_S_RAM: begin
          case (tgt_q)
            EXTERNAL_DATA_SPACE_TGT_ONCHIP: begin
              if (wr_q) begin
                ram_q[12'(ea_q & mask)] <= wd_q; // RULE4
              end
              mv_rdata_o <= ram_q[12'(ea_q & mask)];
              // done rises with the last action, so a held request drops on it
              mv_done_o <= 1'b1;
              st_q <= EXTERNAL_DATA_SPACE_S_DONE;
            end
            EXTERNAL_DATA_SPACE_TGT_FIFO: begin
              fifo_req_tgl_o <= ~fifo_req_tgl_o; // RULE8
              ack_seen_q <= ack_s2_q;
              st_q <= EXTERNAL_DATA_SPACE_S_FIFO;
            end
            EXTERNAL_DATA_SPACE_TGT_FLASH: begin
              fl_wr_o <= 1'b1; // RULE21
              mv_done_o <= 1'b1;
              st_q <= EXTERNAL_DATA_SPACE_S_DONE;
            end
            default: begin
              cnt_q <= EXTERNAL_DATA_SPACE_STROBE_CYC;
              st_q <= EXTERNAL_DATA_SPACE_S_EXT; // RULE12
            end
          endcase
        end
        EXTERNAL_DATA_SPACE_S_FIFO: begin
          // usb clock must run, or this waits forever
          if (ack_s2_q != ack_seen_q) begin
            mv_rdata_o <= d_s2_q; // RULE22 RULE9
            mv_done_o <= 1'b1;
            st_q <= EXTERNAL_DATA_SPACE_S_DONE;
          end
        end
        EXTERNAL_DATA_SPACE_S_EXT: begin
          if (cnt_q == 4'h1) begin
            mv_rdata_o <= dat_s2_q;
            mv_done_o <= 1'b1;
            st_q <= EXTERNAL_DATA_SPACE_S_DONE;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        EXTERNAL_DATA_SPACE_S_DONE: begin
          // dead cycle: a request still held on the done edge is not retaken
          st_q <= EXTERNAL_DATA_SPACE_S_IDLE;
        end
        default: st_q <= EXTERNAL_DATA_SPACE_S_IDLE;
      endcase
    end
  end

  // buffer request fields held stable while the toggle crosses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_wr_o <= 1'b0;
      fifo_addr_o <= 10'h000;
      fifo_wdata_o <= 8'h00;
      fl_addr_o <= 16'h0000;
      fl_data_o <= 8'h00;
    end else if (st_q == EXTERNAL_DATA_SPACE_S_RAM) begin
      fifo_wr_o <= wr_q;
      fifo_addr_o <= ea_q[9:0];
      fifo_wdata_o <= wd_q;
      fl_addr_o <= ea_q;
      fl_data_o <= wd_q;
    end
  end

  // ==========================================================================
  // port pins; drive mode stays with the port configuration
  logic ext_go, hi_drv;
  assign ext_go = (st_q == EXTERNAL_DATA_SPACE_S_RAM) && (tgt_q == EXTERNAL_DATA_SPACE_TGT_OFFCHIP);
  // split mode without bank select leaves the high byte to the latches on register-operand moves
  assign hi_drv = !(emd == EXTERNAL_DATA_SPACE_EMD_SPLIT_NB && !ptr_q);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      off_chip_memory_port_claim_o <= 1'b0;
      ahi_o <= 8'hff;
      ahi_oe_o <= 1'b0;
      alo_o <= 8'hff;
      alo_oe_o <= 1'b0;
      dat_o <= 8'hff;
      dat_oe_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      ale_o <= 1'b0;
    end else if (ext_go) begin
      off_chip_memory_port_claim_o <= 1'b1; // RULE11 RULE12 RULE14
      ahi_o <= ea_q[15:8];
      ahi_oe_o <= hi_drv;
      alo_o <= ea_q[7:0];
      alo_oe_o <= 1'b1;
      dat_o <= wd_q;
      dat_oe_o <= wr_q; // RULE13
      rd_n_o <= wr_q;
      wr_n_o <= !wr_q;
      ale_o <= !cfg_q[EXTERNAL_DATA_SPACE_CFG_MUX_BIT];
    end else if (st_q != EXTERNAL_DATA_SPACE_S_EXT) begin
      off_chip_memory_port_claim_o <= 1'b0; // RULE12
      ahi_oe_o <= 1'b0;
      alo_oe_o <= 1'b0;
      dat_oe_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      ale_o <= 1'b0;
    end else begin
      ale_o <= 1'b0;
    end
  end
endmodule // external_data_space_off_chip_memory_port

/* File: design/external_data_space_pkg.sv */
// external_data_space_pkg: register offsets, field positions, reset values and timing
// assumes a single 125 MHz system clock domain and an APB host
package external_data_space_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] EXTERNAL_DATA_SPACE_PAGE_OFF = 8'h00;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_CFG_OFF = 8'h04;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_DPH_OFF = 8'h08;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_DPL_OFF = 8'h0c;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_R0_OFF = 8'h10;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_R1_OFF = 8'h14;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_FLCTL_OFF = 8'h18;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_STAT_OFF = 8'h1c;
  // ==========================================================================
  // field positions and reset values
  localparam int EXTERNAL_DATA_SPACE_CFG_FAE_BIT = 6;
  localparam int EXTERNAL_DATA_SPACE_CFG_MUX_BIT = 4;
  localparam int EXTERNAL_DATA_SPACE_CFG_EMD_LSB = 2;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_CFG_RST = 8'h03;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_CFG_WMASK = 8'h5f;
  localparam logic [7:0] EXTERNAL_DATA_SPACE_PAGE_RST = 8'h00;
  // ==========================================================================
  // memory map
  localparam logic [15:0] EXTERNAL_DATA_SPACE_FIFO_LO = 16'h0400;
  localparam logic [15:0] EXTERNAL_DATA_SPACE_FIFO_HI = 16'h07ff;
  localparam logic [15:0] EXTERNAL_DATA_SPACE_SPLIT_BOUND = 16'h2000;
  localparam logic [15:0] EXTERNAL_DATA_SPACE_ONCHIP_MASK_4K = 16'h0fff;
  localparam logic [15:0] EXTERNAL_DATA_SPACE_ONCHIP_MASK_2K = 16'h07ff;
  localparam logic [1:0] EXTERNAL_DATA_SPACE_EMD_INT = 2'h0;
  localparam logic [1:0] EXTERNAL_DATA_SPACE_EMD_SPLIT_NB = 2'h1;
  localparam logic [1:0] EXTERNAL_DATA_SPACE_EMD_SPLIT_B = 2'h2;
  localparam logic [1:0] EXTERNAL_DATA_SPACE_EMD_EXT = 2'h3;
  // ==========================================================================
  // off-chip strobe timing
  localparam int EXTERNAL_DATA_SPACE_STROBE_NS = 40;
  localparam int EXTERNAL_DATA_SPACE_CLK_NS = 8;
  localparam logic [3:0] EXTERNAL_DATA_SPACE_STROBE_CYC =
    4'((EXTERNAL_DATA_SPACE_STROBE_NS + EXTERNAL_DATA_SPACE_CLK_NS - 1) / EXTERNAL_DATA_SPACE_CLK_NS);
  // ==========================================================================
  // access targets and controller states
  typedef enum logic [1:0] {
    EXTERNAL_DATA_SPACE_TGT_ONCHIP = 2'h0,
    EXTERNAL_DATA_SPACE_TGT_FIFO = 2'h1,
    EXTERNAL_DATA_SPACE_TGT_OFFCHIP = 2'h2,
    EXTERNAL_DATA_SPACE_TGT_FLASH = 2'h3
  } external_data_space_tgt_t;
  typedef enum logic [4:0] {
    EXTERNAL_DATA_SPACE_S_IDLE = 5'h01,
    EXTERNAL_DATA_SPACE_S_RAM = 5'h02,
    EXTERNAL_DATA_SPACE_S_FIFO = 5'h04,
    EXTERNAL_DATA_SPACE_S_EXT = 5'h08,
    EXTERNAL_DATA_SPACE_S_DONE = 5'h10
  } external_data_space_state_t;
endpackage

/* File: verification/external_data_space_off_chip_memory_port_models.sv */
// external_data_space_off_chip_memory_port_models: off-chip async memory and usb buffer responder
// assumes non-multiplexed pins and the toggle handshake of the design
`timescale 1ns/10ps
module external_data_space_ext_mem (
  input wire logic clk_i,
  input wire logic [7:0] ahi_i,
  input wire logic [7:0] alo_i,
  input wire logic [7:0] dat_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [7:0] dat_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q = 8'h5a;
  // released bus shows a pattern, never the last value
  always @(posedge clk_i) junk_q <= ~junk_q ^ 8'h3c;
  always @(posedge clk_i) if (!wr_n_i) mem[{ahi_i, alo_i}] <= dat_i;
  assign dat_o = rd_n_i ? junk_q : mem[{ahi_i, alo_i}];
endmodule // external_data_space_ext_mem

module external_data_space_usb_buf (
  input wire logic clk_i,
  input wire logic [3:0] lat_i,
  input wire logic req_tgl_i,
  input wire logic wr_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_tgl_o = 1'b0,
  output logic [7:0] rdata_o = 8'ha5
);
  logic [7:0] mem [0:1023];
  logic seen_q = 1'b0;
  int cnt = 0;
  // slow or prompt answer by lat_i
  always @(posedge clk_i) begin
    if (req_tgl_i != seen_q) begin
      cnt++;
      if (cnt >= lat_i) begin
        if (wr_i) mem[addr_i] <= wdata_i;
        else rdata_o <= mem[addr_i];
        ack_tgl_o <= ~ack_tgl_o;
        seen_q <= req_tgl_i;
        cnt = 0;
      end
    end else rdata_o <= ~rdata_o;
  end
endmodule // external_data_space_usb_buf

/* File: verification/external_data_space_off_chip_memory_port_props.sv */
// external_data_space_off_chip_memory_port_props: port-level checks of the move engine and pin claim
// assumes it is bound onto external_data_space_off_chip_memory_port and sees only its ports
`timescale 1ns/10ps
module external_data_space_off_chip_memory_port_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mv_done_o,
  input wire logic fl_wr_o,
  input wire logic fifo_req_tgl_o,
  input wire logic fifo_wr_o,
  input wire logic [9:0] fifo_addr_o,
  input wire logic fifo_ack_tgl_i,
  input wire logic off_chip_memory_port_claim_o,
  input wire logic ahi_oe_o,
  input wire logic dat_oe_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic alo_oe_o,
  input wire logic ale_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // buffer request outstanding
  logic rq_q, ak_q, pend_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rq_q <= 1'b0;
      ak_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      rq_q <= fifo_req_tgl_o;
      ak_q <= fifo_ack_tgl_i;
      if (fifo_req_tgl_o != rq_q) pend_q <= 1'b1;
      else if (fifo_ack_tgl_i != ak_q) pend_q <= 1'b0;
    end
  end
  // ====
  // assertions
  a_fifo_hold_req: assert property (pend_q && fifo_req_tgl_o == rq_q |->
    $stable(fifo_addr_o) && $stable(fifo_wr_o))
    else $error("buffer request changed before ack");
  a_fifo_wait_ack: assert property ($changed(fifo_req_tgl_o) |->
    !mv_done_o [*3])
    else $error("buffer move done too early");
  a_fifo_no_pins: assert property ($changed(fifo_req_tgl_o) |->
    !off_chip_memory_port_claim_o)
    else $error("pins claimed for buffer move");
  a_flash_no_pins: assert property (fl_wr_o |->
    !off_chip_memory_port_claim_o && $stable(fifo_req_tgl_o))
    else $error("flash write reached another target");
  a_idle_pins_free: assert property (!off_chip_memory_port_claim_o |->
    rd_n_o && wr_n_o && !ahi_oe_o && !dat_oe_o)
    else $error("pins driven without claim");
  a_read_no_drive: assert property (!rd_n_o |->
    !dat_oe_o && off_chip_memory_port_claim_o)
    else $error("data driven during read");
  a_write_drives: assert property (!wr_n_o |->
    dat_oe_o && off_chip_memory_port_claim_o)
    else $error("write strobe without data drive");
  a_claim_bounded: assert property ($rose(off_chip_memory_port_claim_o) |->
    ##[1:12] mv_done_o)
    else $error("claim without move completion");
  a_release_done: assert property (mv_done_o |=> !off_chip_memory_port_claim_o)
    else $error("pins kept after move");
  a_ale_in_claim: assert property (ale_o |->
    off_chip_memory_port_claim_o && alo_oe_o && rd_n_o != wr_n_o)
    else $error("address latch pulse outside a claimed access");
  c_offchip: cover property ($rose(off_chip_memory_port_claim_o));
  c_fifo: cover property ($changed(fifo_req_tgl_o));
  c_flash: cover property (fl_wr_o);
  c_mux: cover property (ale_o);
endmodule // external_data_space_off_chip_memory_port_props

bind external_data_space_off_chip_memory_port external_data_space_off_chip_memory_port_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .mv_done_o(mv_done_o), .fl_wr_o(fl_wr_o), .fifo_wr_o(fifo_wr_o),
  .fifo_req_tgl_o(fifo_req_tgl_o), .fifo_addr_o(fifo_addr_o),
  .fifo_ack_tgl_i(fifo_ack_tgl_i), .off_chip_memory_port_claim_o(off_chip_memory_port_claim_o),
  .ahi_oe_o(ahi_oe_o), .dat_oe_o(dat_oe_o), .rd_n_o(rd_n_o),
  .wr_n_o(wr_n_o), .alo_oe_o(alo_oe_o), .ale_o(ale_o));

/* File: verification/external_data_space_off_chip_memory_port_tb.sv */
// external_data_space_off_chip_memory_port_tb: register, on-chip, buffer, flash and off-chip moves
// assumes the models file and the bound checker are compiled first
`timescale 1ns/10ps
module external_data_space_off_chip_memory_port_tb;
  import external_data_space_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, psel = 0, pen = 0, pwr = 0, err;
  logic mreq = 0, mwr = 0, mptr = 0, midx = 0, x, prdy, perr, mdone, flw;
  logic ftg, fwr, fak, clm, rdn, wrn;
  logic [7:0] padr = 0, mwd = 0, mrd, mrdo, ahi, alo, dout, din, frd, fwd;
  logic [7:0] fld, fl_d, d, sh [0:4095];
  logic [31:0] pwd = 0, prd, rd;
  logic [15:0] fla, fl_a, a;
  logic [9:0] fad;
  logic [3:0] lat = 4'h2;
  int num_errors = 0, check_count = 0, lo, lf;
  always #4 clk_i = ~clk_i;
  external_data_space_off_chip_memory_port dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .mv_req_i(mreq),
    .mv_wr_i(mwr), .mv_ptr_i(mptr), .mv_idx_i(midx), .mv_wdata_i(mwd),
    .mv_done_o(mdone), .mv_rdata_o(mrdo), .fl_wr_o(flw), .fl_addr_o(fla),
    .fl_data_o(fld), .fifo_req_tgl_o(ftg), .fifo_wr_o(fwr),
    .fifo_addr_o(fad), .fifo_wdata_o(fwd), .fifo_ack_tgl_i(fak),
    .fifo_rdata_i(frd), .off_chip_memory_port_claim_o(clm), .ahi_o(ahi), .ahi_oe_o(),
    .alo_o(alo), .alo_oe_o(), .dat_o(dout), .dat_oe_o(), .dat_i(din),
    .rd_n_o(rdn), .wr_n_o(wrn), .ale_o());
  external_data_space_ext_mem em (.clk_i(clk_i), .ahi_i(ahi), .alo_i(alo), .dat_i(dout),
    .rd_n_i(rdn), .wr_n_i(wrn), .dat_o(din));
  external_data_space_usb_buf ub (.clk_i(clk_i), .lat_i(lat), .req_tgl_i(ftg), .wr_i(fwr),
    .addr_i(fad), .wdata_i(fwd), .ack_tgl_o(fak), .rdata_o(frd));
  always @(posedge clk_i) if (flw === 1'b1) {fl_a, fl_d} <= {fla, fld};
  // ====
  // bus and move tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk_i);
    psel <= 1'b1; pwr <= w; padr <= ad; pwd <= v;
    @(posedge clk_i);
    pen <= 1'b1;
    // wait for the edge that samples pready high; the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pt(input logic [15:0] ad);
    apb(1'b1, EXTERNAL_DATA_SPACE_DPH_OFF, {24'h0, ad[15:8]});
    apb(1'b1, EXTERNAL_DATA_SPACE_DPL_OFF, {24'h0, ad[7:0]});
  endtask
  task automatic ix(input logic [15:0] ad, input logic s);
    apb(1'b1, EXTERNAL_DATA_SPACE_PAGE_OFF, {24'h0, ad[15:8]});
    apb(1'b1, s ? EXTERNAL_DATA_SPACE_R1_OFF : EXTERNAL_DATA_SPACE_R0_OFF, {24'h0, ad[7:0]});
  endtask
  // request drops on the edge that samples done; no latency is assumed
  task automatic mv(input logic w, p, s, input logic [7:0] v, output int n);
    @(posedge clk_i);
    mreq <= 1'b1; mwr <= w; mptr <= p; midx <= s; mwd <= v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (mdone !== 1'b1);
    mrd = mrdo;
    mreq <= 1'b0;
  endtask
  function automatic logic [7:0] xp(input logic [15:0] ad);
    return sh[ad & EXTERNAL_DATA_SPACE_ONCHIP_MASK_4K];
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  // ====
  // main sequence
  initial begin
    void'($urandom(644));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h0); chk(rd, EXTERNAL_DATA_SPACE_CFG_RST);
    apb(1'b0, 8'h20, 32'h0); chk(err, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'hffff : 16'($urandom);
      d = 8'($urandom); x = 1'($urandom);
      pt(a); mv(1'b1, 1'b1, 1'b0, d, lo); sh[a[11:0]] = d;
      apb(1'b0, EXTERNAL_DATA_SPACE_DPL_OFF, 32'h0); chk(rd, {24'h0, a[7:0]});
      ix(a ^ 16'h1000, x); mv(1'b0, 1'b0, x, 8'h0, lo);
      chk(mrd, xp(a));
      apb(1'b0, EXTERNAL_DATA_SPACE_PAGE_OFF, 32'h0); chk(rd, {24'h0, a[15:8] ^ 8'h10});
      pt(a); mv(1'b0, 1'b1, 1'b0, 8'h0, lo); chk(mrd, d);
    end
    $display("test on-chip done");
    pt(16'h0520); mv(1'b1, 1'b1, 1'b0, 8'h11, lo);
    apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h43);
    lat <= 4'h5;
    mv(1'b1, 1'b1, 1'b0, 8'h22, lf);
    chk(ub.mem[10'h120], 8'h22);
    chk(lf > lo, 32'h1);
    lat <= 4'h1;
    ix(16'h0520, 1'b1); mv(1'b0, 1'b0, 1'b1, 8'h0, lf);
    chk(mrd, 8'h22);
    apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h03);
    pt(16'h0520); mv(1'b0, 1'b1, 1'b0, 8'h0, lo); chk(mrd, 8'h11);
    $display("test buffer done");
    pt(16'h1234); mv(1'b1, 1'b1, 1'b0, 8'h77, lo);
    apb(1'b1, EXTERNAL_DATA_SPACE_FLCTL_OFF, 32'h1);
    mv(1'b1, 1'b1, 1'b0, 8'h5a, lo);
    @(posedge clk_i);
    chk({fl_a, fl_d}, 24'h12345a);
    apb(1'b1, EXTERNAL_DATA_SPACE_FLCTL_OFF, 32'h0);
    mv(1'b0, 1'b1, 1'b0, 8'h0, lo); chk(mrd, 8'h77);
    $display("test flash done");
    // pin mode first, memory mode last
    apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h13);
    apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h1f);
    for (int i = 0; i < 4; i++) begin
      // second half of the run uses the multiplexed pin mode
      if (i == 2) apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h0f);
      a = 16'($urandom); d = 8'($urandom); x = 1'($urandom);
      pt(a); mv(1'b1, 1'b1, 1'b0, d, lo); chk(em.mem[a], d);
      ix(a, x); mv(1'b0, 1'b0, x, 8'h0, lo); chk(mrd, d);
    end
    // split with bank select: low space stays on-chip, high goes off-chip
    apb(1'b1, EXTERNAL_DATA_SPACE_CFG_OFF, 32'h1b);
    pt(16'h0520); mv(1'b0, 1'b1, 1'b0, 8'h0, lo);
    chk(mrd, 8'h11);
    ix(16'h3456, 1'b0); mv(1'b1, 1'b0, 1'b0, 8'hc3, lo);
    chk(em.mem[16'h3456], 8'hc3);
    $display("test off-chip done");
    close_out();
  end
endmodule // external_data_space_off_chip_memory_port_tb
